// ==== cdw_defs.svh ====
// Constants of the configuration word decoder: offsets, field positions, reset values, timing.
// Assumes inclusion by the design modules and the bench; definitions only.
`ifndef CDW_DEFS_SVH
`define CDW_DEFS_SVH
`define CDW_AW 14
`define CDW_DW 14
`define CDW_ADDR_CFG1 14'h2007
`define CDW_ADDR_CFG2 14'h2008
`define CDW_ADDR_PWRCTL 14'h008E
`define CDW_ADDR_STATUS 14'h0090
`define CDW_CFG_RST 14'h3FFF
`define CDW_PWRCTL_RST 1'b0
`define CDW_CFG1_ONES 14'h0600
`define CDW_CFG2_ONES 14'h3FBC
`define CDW_B_CP 13
`define CDW_B_CAPTURE_UNIT_TWO_PIN_SELECT 12
`define CDW_B_DEBUG 11
`define CDW_B_BROWNOUT_LEVEL_FIELD_HI 8
`define CDW_B_BROWNOUT_LEVEL_FIELD_LO 7
`define CDW_B_BROWNOUT_ENABLE_BIT 6
`define CDW_B_RESET_PIN_FUNCTION_SELECT 5
`define CDW_B_FOSC2 4
`define CDW_B_POWER_UP_DELAY_ENABLE_N 3
`define CDW_B_WATCHDOG_ENABLE_BIT 2
`define CDW_B_FOSC1 1
`define CDW_B_FOSC0 0
`define CDW_B_BROWNOUT_SLEEP_MODE_BIT 6
`define CDW_B_SOFTWARE_BROWNOUT_ENABLE 2
`define CDW_OSC_EXT 3'h3
`define CDW_CLK_KHZ 100000
`define CDW_POWER_UP_DELAY_TIMER_MS 72
`define CDW_POWER_UP_DELAY_TIMER_CYCLES (`CDW_POWER_UP_DELAY_TIMER_MS * `CDW_CLK_KHZ)
`define CDW_POWER_UP_DELAY_TIMER_W 23
`define CDW_OST_OSC_CYCLES 1024
`define CDW_OST_W 11
`endif

// ==== cdw_pkg.sv ====
// Types shared by the configuration word decoder modules.
// Assumes cdw_defs.svh is on the include path.
package cdw_pkg;
  typedef enum logic [2:0] {
    CDW_SEQ_PROG,
    CDW_SEQ_POWER_UP_DELAY_TIMER,
    CDW_SEQ_OST,
    CDW_SEQ_RUN,
    CDW_SEQ_SLEEP,
    CDW_SEQ_EXTRST
  } cdw_seq_type;
endpackage

// ==== cdw_cnt_if.sv ====
// Start, tick and done of one delay counter.
// Assumes one controller and one counter on the same clock.
`timescale 1ns/1ps
interface cdw_cnt_if;
  logic start;
  logic tick;
  logic done;
  modport ctl (output start, output tick, input done);
  modport cnt (input start, input tick, output done);
endinterface

// ==== cdw_sync3.sv ====
// Three-stage pin synchroniser; the level changes once stages two and three agree.
// Assumes an asynchronous pin and the block clock.
`timescale 1ns/1ps
module cdw_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level_q
);
  logic ff1_q;
  logic ff2_q;
  logic ff3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1_q <= RST_VAL;
      ff2_q <= RST_VAL;
      ff3_q <= RST_VAL;
      level_q <= RST_VAL;
    end else begin
      ff1_q <= pin_in;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      if (ff2_q == ff3_q) begin
        level_q <= ff3_q;
      end
    end
  end

  a_sync_level_agree: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(level_q) |-> $past(ff2_q) == $past(ff3_q))
    else $error("synchronised level moved without agreement");
endmodule

// ==== cdw_delay_cnt.sv ====
// Delay counter: cleared by start, counts ticks, done stays high after TERM ticks.
// Assumes start is a one-cycle pulse from the controller.
`timescale 1ns/1ps
`include "cdw_defs.svh"
module cdw_delay_cnt #(
  parameter int CNT_W = `CDW_OST_W,
  parameter int TERM = `CDW_OST_OSC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  cdw_cnt_if.cnt ctl
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TERM - 1);
  logic [CNT_W-1:0] cnt_q;
  logic done_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (ctl.start) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (ctl.tick && !done_q) begin
      cnt_q <= cnt_q + 1'b1;
      done_q <= (cnt_q == LAST);
    end
  end

  assign ctl.done = done_q;

  a_cnt_done_term: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(done_q) |-> $past(cnt_q) == LAST && $past(ctl.tick))
    else $error("delay counter finished at the wrong count");
endmodule

// ==== cdw_config_decode.sv ====
// Configuration word decoder: holds both configuration words, decodes them into core settings,
// and sequences power-up, crystal settling, sleep and external reset.
// Assumes same-clock strobes on the register port and asynchronous pins for prog, reset and osc.
//
// Overview of operation
// RULE1 - A configuration bit reads 0 when programmed, 1 when unprogrammed.
// RULE2 - The configuration words sit at program addresses 2007h and 2008h.
// RULE3 - Configuration words are read or written only while in programming mode.
// RULE4 - Code-protect 1 leaves memory open; 0 protects all memory from 0000h.
// RULE5 - Capture unit two pin select 1 routes to alt pin a, 0 to b.
// RULE6 - Debugger bit 1 frees the debugger pins; 0 gives them to the debugger.
// RULE7 - Brown-out level 11=2.0V, 10=2.7V, 01=4.2V, 00=4.5V.
// RULE8 - Brown-out enable and sleep mode: on, awake-only, software, off.
// RULE9 - Reset pin select 1 uses pin as reset; 0 makes internal reset inactive.
// RULE10 - Power-up delay of 72 ms holds reset, only at power-up, if enabled.
// RULE11 - Oscillator select: 011 external clock, 010 high speed, 001 standard, 000 low power.
// RULE12 - Crystal settle timer holds reset until the crystal is stable.
// RULE13 - Sleep ends on external reset, watchdog wake-up or enabled interrupt.
// RULE14 - Software brown-out enable is bit 2 of the power control register.
// RULE15 - After the power-up delay the settle timer counts 1024 oscillator cycles.
// RULE16 - Settle delay only in crystal modes, only at power-on or wake from sleep.
// RULE17 - Power-up delay enable is active low.
// RULE18 - Watchdog enable bit 1 turns the watchdog on, 0 off.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "cdw_defs.svh"
module cdw_config_decode
  import cdw_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = `CDW_POWER_UP_DELAY_TIMER_CYCLES,
  parameter int OST_CYCLES = `CDW_OST_OSC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_req,
  input wire logic prog_mode_pin,
  input wire logic ext_reset_pin_n,
  input wire logic osc_in_pin,
  input wire logic wdt_timeout,
  input wire logic irq_wake,
  input wire logic sleep_req,
  input wire logic [`CDW_AW-1:0] reg_addr,
  input wire logic [`CDW_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`CDW_DW-1:0] reg_rdata_q,
  output logic code_protect_q,
  output logic capture_unit_alt_pin_a_sel_q,
  output logic debugger_pins_owned_q,
  output logic [1:0] brownout_level_q,
  output logic brownout_active_q,
  output logic ext_reset_gated_n_q,
  output logic watchdog_on_q,
  output logic [2:0] oscillator_select_q,
  output logic osc2_port_io_q,
  output logic core_hold_q,
  output logic sleeping_q
);
  logic prog_lvl;
  logic external_reset_pin_lvl;
  logic osc_lvl;
  logic osc_prev_q;
  logic [`CDW_DW-1:0] cfg1_q;
  logic [`CDW_DW-1:0] cfg1_d;
  logic [`CDW_DW-1:0] cfg2_q;
  logic [`CDW_DW-1:0] cfg2_d;
  logic sbore_q;
  logic sbore_d;
  logic [`CDW_DW-1:0] rdata_d;
  cdw_seq_type seq_q;
  cdw_seq_type seq_d;
  cdw_seq_type power_up_state;

  cdw_cnt_if power_up_delay_timer_if ();
  cdw_cnt_if ost_if ();

  // Pins cross into the clock domain through three stages each
  cdw_sync3 #(.RST_VAL(1'b0)) u_sync_prog (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(prog_mode_pin),
    .level_q(prog_lvl)
  );

  cdw_sync3 #(.RST_VAL(1'b1)) u_sync_external_reset_pin (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(ext_reset_pin_n),
    .level_q(external_reset_pin_lvl)
  );

  // Oscillator edges are counted after synchronising, so the pin must run below a quarter of clk
  cdw_sync3 #(.RST_VAL(1'b0)) u_sync_osc (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(osc_in_pin),
    .level_q(osc_lvl)
  );

  cdw_delay_cnt #(.CNT_W(`CDW_POWER_UP_DELAY_TIMER_W), .TERM(POWER_UP_DELAY_TIMER_CYCLES)) u_power_up_delay_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ctl(power_up_delay_timer_if.cnt)
  );

  cdw_delay_cnt #(.CNT_W(`CDW_OST_W), .TERM(OST_CYCLES)) u_ost (
    .clk(clk),
    .rst_n(rst_n),
    .ctl(ost_if.cnt)
  );

  // Register decode
  wire hit_cfg1 = (reg_addr == `CDW_ADDR_CFG1); // RULE2
  wire hit_cfg2 = (reg_addr == `CDW_ADDR_CFG2); // RULE2
  wire hit_pwrctl = (reg_addr == `CDW_ADDR_PWRCTL);
  wire hit_status = (reg_addr == `CDW_ADDR_STATUS);
  wire cfg_open = prog_lvl; // RULE3
  wire wr_cfg1 = reg_wr && hit_cfg1 && cfg_open; // RULE3
  wire wr_cfg2 = reg_wr && hit_cfg2 && cfg_open; // RULE3
  wire wr_pwrctl = reg_wr && hit_pwrctl;

  // Unimplemented configuration bits read back as 1, except bits 1:0 of the second word, which keep the written value
  assign cfg1_d = wr_cfg1 ? (reg_wdata | `CDW_CFG1_ONES) : cfg1_q;
  assign cfg2_d = wr_cfg2 ? (reg_wdata | `CDW_CFG2_ONES) : cfg2_q;
  assign sbore_d = wr_pwrctl ? reg_wdata[`CDW_B_SOFTWARE_BROWNOUT_ENABLE] : sbore_q; // RULE14

  wire [`CDW_DW-1:0] pwrctl_view = `CDW_DW'({sbore_q, 2'b00}); // RULE14
  wire [`CDW_DW-1:0] status_view = {9'h000, prog_lvl, core_hold_q, sleeping_q, seq_q == CDW_SEQ_RUN, 1'b0};

  // Outside programming mode the configuration words read as zero
  assign rdata_d = !reg_rd ? '0 :
                   (hit_cfg1 && cfg_open) ? cfg1_q : // RULE3
                   (hit_cfg2 && cfg_open) ? cfg2_q : // RULE3
                   hit_pwrctl ? pwrctl_view :
                   hit_status ? status_view : '0;

  // Field decode; 0 means programmed
  wire cp_bit = cfg1_q[`CDW_B_CP]; // RULE1
  wire capture_unit_two_pin_select_bit = cfg1_q[`CDW_B_CAPTURE_UNIT_TWO_PIN_SELECT];
  wire debug_bit = cfg1_q[`CDW_B_DEBUG];
  wire [1:0] brownout_level_field_field = cfg1_q[`CDW_B_BROWNOUT_LEVEL_FIELD_HI:`CDW_B_BROWNOUT_LEVEL_FIELD_LO];
  wire brownout_enable_bit_bit = cfg1_q[`CDW_B_BROWNOUT_ENABLE_BIT];
  wire brownout_sleep_mode_bit_bit = cfg2_q[`CDW_B_BROWNOUT_SLEEP_MODE_BIT];
  wire reset_pin_function_select_bit = cfg1_q[`CDW_B_RESET_PIN_FUNCTION_SELECT];
  wire power_up_delay_enable_n_n_bit = cfg1_q[`CDW_B_POWER_UP_DELAY_ENABLE_N];
  wire watchdog_enable_bit_bit = cfg1_q[`CDW_B_WATCHDOG_ENABLE_BIT];
  wire [2:0] osc_sel = {cfg1_q[`CDW_B_FOSC2], cfg1_q[`CDW_B_FOSC1], cfg1_q[`CDW_B_FOSC0]}; // RULE11
  wire xtal_mode = (osc_sel < `CDW_OSC_EXT); // RULE16
  wire power_up_delay_timer_enabled = !power_up_delay_enable_n_n_bit; // RULE17
  wire rst_pin_asserted = reset_pin_function_select_bit && !external_reset_pin_lvl; // RULE9
  wire wdt_event = watchdog_enable_bit_bit && wdt_timeout; // RULE18
  wire osc_rise = osc_lvl && !osc_prev_q;

  // Brown-out: both bits set always on, enable only is awake-only, sleep bit only is software
  wire bor_active_d = (brownout_enable_bit_bit && brownout_sleep_mode_bit_bit) ||
                      (brownout_enable_bit_bit && !brownout_sleep_mode_bit_bit && seq_d != CDW_SEQ_SLEEP) ||
                      (!brownout_enable_bit_bit && brownout_sleep_mode_bit_bit && sbore_q); // RULE8

  // Power-up path: delay if enabled, then settle for crystals, else run
  assign power_up_state = power_up_delay_timer_enabled ? CDW_SEQ_POWER_UP_DELAY_TIMER : // RULE10
                          xtal_mode ? CDW_SEQ_OST : CDW_SEQ_RUN; // RULE15

  always_comb begin
    seq_d = seq_q;
    if (prog_lvl) begin
      seq_d = CDW_SEQ_PROG;
    end else if (por_req) begin
      seq_d = power_up_state;
    end else if (rst_pin_asserted) begin
      seq_d = CDW_SEQ_EXTRST;
    end else begin
      unique case (seq_q)
        CDW_SEQ_PROG: begin
          seq_d = power_up_state;
        end
        CDW_SEQ_POWER_UP_DELAY_TIMER: begin
          if (power_up_delay_timer_if.done) begin
            seq_d = xtal_mode ? CDW_SEQ_OST : CDW_SEQ_RUN; // RULE15
          end
        end
        CDW_SEQ_OST: begin
          if (ost_if.done) begin
            seq_d = CDW_SEQ_RUN; // RULE12
          end
        end
        CDW_SEQ_RUN: begin
          if (wdt_event) begin
            seq_d = CDW_SEQ_EXTRST;
          end else if (sleep_req) begin
            seq_d = CDW_SEQ_SLEEP;
          end
        end
        CDW_SEQ_SLEEP: begin
          if (irq_wake || wdt_event) begin
            seq_d = xtal_mode ? CDW_SEQ_OST : CDW_SEQ_RUN; // RULE13 RULE16
          end
        end
        CDW_SEQ_EXTRST: begin
          seq_d = CDW_SEQ_RUN;
        end
        default: begin
          seq_d = CDW_SEQ_PROG;
        end
      endcase
    end
  end

  // Counters restart on entry, or when a power-on event lands while already counting
  assign power_up_delay_timer_if.start = (seq_d == CDW_SEQ_POWER_UP_DELAY_TIMER) && (seq_q != CDW_SEQ_POWER_UP_DELAY_TIMER || por_req); // RULE10
  assign power_up_delay_timer_if.tick = 1'b1;
  assign ost_if.start = (seq_d == CDW_SEQ_OST) && (seq_q != CDW_SEQ_OST || por_req); // RULE15
  assign ost_if.tick = osc_rise; // RULE15

  // Configuration storage starts unprogrammed after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_q <= `CDW_CFG_RST;
      cfg2_q <= `CDW_CFG_RST;
      sbore_q <= `CDW_PWRCTL_RST;
      osc_prev_q <= 1'b0;
      seq_q <= CDW_SEQ_PROG;
    end else begin
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      sbore_q <= sbore_d;
      osc_prev_q <= osc_lvl;
      seq_q <= seq_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= '0;
      code_protect_q <= 1'b0;
      capture_unit_alt_pin_a_sel_q <= 1'b1;
      debugger_pins_owned_q <= 1'b0;
      brownout_level_q <= 2'h3;
      brownout_active_q <= 1'b0;
      ext_reset_gated_n_q <= 1'b1;
      watchdog_on_q <= 1'b0;
      oscillator_select_q <= 3'h7;
      osc2_port_io_q <= 1'b0;
      core_hold_q <= 1'b1;
      sleeping_q <= 1'b0;
    end else begin
      reg_rdata_q <= rdata_d;
      code_protect_q <= !cp_bit; // RULE4
      capture_unit_alt_pin_a_sel_q <= capture_unit_two_pin_select_bit; // RULE5
      debugger_pins_owned_q <= !debug_bit; // RULE6
      brownout_level_q <= brownout_level_field_field; // RULE7
      brownout_active_q <= bor_active_d; // RULE8
      ext_reset_gated_n_q <= reset_pin_function_select_bit ? external_reset_pin_lvl : 1'b1; // RULE9
      watchdog_on_q <= watchdog_enable_bit_bit; // RULE18
      oscillator_select_q <= osc_sel; // RULE11
      osc2_port_io_q <= (osc_sel == `CDW_OSC_EXT); // RULE11
      core_hold_q <= (seq_d != CDW_SEQ_RUN) && (seq_d != CDW_SEQ_SLEEP); // RULE10 RULE12
      sleeping_q <= (seq_d == CDW_SEQ_SLEEP);
    end
  end

  a_cfg_write_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    reg_wr && hit_cfg1 && !prog_lvl |=> $stable(cfg1_q))
    else $error("configuration word changed outside programming mode");

  a_cfg_read_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    reg_rd && (hit_cfg1 || hit_cfg2) && !prog_lvl |=> reg_rdata_q == '0)
    else $error("configuration word visible outside programming mode");

  a_code_protect_pol: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    cfg1_q[`CDW_B_CP] == 1'b0 |=> code_protect_q)
    else $error("programmed code-protect bit did not protect memory");

  a_reset_pin_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    !cfg1_q[`CDW_B_RESET_PIN_FUNCTION_SELECT] |=> ext_reset_gated_n_q)
    else $error("internal reset active while reset pin disabled");

  a_bor_sleep_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    cfg1_q[`CDW_B_BROWNOUT_ENABLE_BIT] && !cfg2_q[`CDW_B_BROWNOUT_SLEEP_MODE_BIT] && seq_d == CDW_SEQ_SLEEP |=> !brownout_active_q)
    else $error("brown-out left on in sleep in awake-only mode");

  a_power_up_delay_timer_holds_core: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    seq_q == CDW_SEQ_POWER_UP_DELAY_TIMER || seq_q == CDW_SEQ_OST |-> core_hold_q)
    else $error("core released during power-up or settle delay");

  a_power_up_delay_timer_then_ost: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    seq_q == CDW_SEQ_POWER_UP_DELAY_TIMER && power_up_delay_timer_if.done && !prog_lvl && !por_req && !rst_pin_asserted && xtal_mode
    |=> seq_q == CDW_SEQ_OST)
    else $error("settle timer not started after power-up delay");

  a_ost_xtal_only: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
    seq_q == CDW_SEQ_OST && $past(seq_q) != CDW_SEQ_OST |-> $past(xtal_mode))
    else $error("settle timer entered outside crystal modes");

  a_sleep_wake_irq: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    seq_q == CDW_SEQ_SLEEP && irq_wake && !prog_lvl && !por_req |=> !sleeping_q ##0 seq_q != CDW_SEQ_SLEEP)
    else $error("interrupt did not end sleep");

  a_wdt_enable_bit: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    $rose(cfg1_q[`CDW_B_WATCHDOG_ENABLE_BIT]) |=> watchdog_on_q ##1 $stable(watchdog_on_q) || !cfg1_q[`CDW_B_WATCHDOG_ENABLE_BIT])
    else $error("watchdog did not follow its enable bit");
endmodule

// ==== cdw_prog_model.sv ====
// Model of the external programmer: owns the programming pin and the register port.
// Assumes the decoder samples its strobes on the rising clock edge and answers reads one cycle later.
`timescale 1ns/1ps
module cdw_prog_model (
  input wire logic clk,
  input wire logic [13:0] reg_rdata_q,
  output logic prog_mode_pin,
  output logic [13:0] reg_addr,
  output logic [13:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    prog_mode_pin = 1'b0;
    reg_addr = 14'h0000;
    reg_wdata = 14'h3FFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // The pin passes a synchroniser, so give it time before the first access
  task prog(input logic on);
    @(posedge clk);
    prog_mode_pin <= on;
    repeat (6) @(posedge clk);
  endtask
  task wr(input logic [13:0] a, input logic [13:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released data must not look like the last word
    reg_wdata <= ~d;
  endtask
  task rd(input logic [13:0] a, output logic [13:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata_q;
  endtask
endmodule

// ==== tb.sv ====
// Self-checking bench of the configuration word decoder.
// Assumes the programmer model drives the register port and the programming pin.
`timescale 1ns/1ps
`include "cdw_defs.svh"
module tb;
  typedef struct packed {logic [13:0] word; logic [7:0] exp;} cdw_row_type;
  logic clk, rst_n, por_req, ext_reset_pin_n, osc_in_pin, wdt_timeout, irq_wake, sleep_req, osc_run;
  wire prog_mode_pin, reg_wr, reg_rd, cp, alt_a, dbg, bo_act, gated_n, wdt_on, osc2_io, hold, sleeping;
  wire [13:0] reg_addr, reg_wdata, reg_rdata_q;
  wire [1:0] bo_lvl;
  wire [2:0] osc_sel;
  wire [7:0] dec = {cp, alt_a, dbg, bo_lvl, osc_sel};
  int errors = 0, samples_checked = 0, rises = 0, n;
  logic [13:0] d;
  logic seen;
  // Expected decode: code protect, pin a, debugger, level, oscillator
  cdw_row_type rows [5] = '{'{14'h3FFF, 8'h5F}, '{14'h074B, 8'hB3}, '{14'h3EAE, 8'h4A},
                            '{14'h3E6D, 8'h41}, '{14'h3FEC, 8'h58}};
  cdw_prog_model u_cdw_prog_model (.clk(clk), .reg_rdata_q(reg_rdata_q), .prog_mode_pin(prog_mode_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  cdw_config_decode #(.POWER_UP_DELAY_TIMER_CYCLES(20), .OST_CYCLES(8)) u_cdw_config_decode (.clk(clk), .rst_n(rst_n),
    .por_req(por_req), .prog_mode_pin(prog_mode_pin), .ext_reset_pin_n(ext_reset_pin_n),
    .osc_in_pin(osc_in_pin), .wdt_timeout(wdt_timeout), .irq_wake(irq_wake), .sleep_req(sleep_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .code_protect_q(cp), .capture_unit_alt_pin_a_sel_q(alt_a),
    .debugger_pins_owned_q(dbg), .brownout_level_q(bo_lvl), .brownout_active_q(bo_act),
    .ext_reset_gated_n_q(gated_n), .watchdog_on_q(wdt_on), .oscillator_select_q(osc_sel),
    .osc2_port_io_q(osc2_io), .core_hold_q(hold), .sleeping_q(sleeping));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Crystal runs at about a seventh of the clock, unrelated to it in phase
  always begin
    #37;
    if (osc_run) begin
      osc_in_pin = ~osc_in_pin;
      rises = rises + osc_in_pin;
    end
  end
  task final_report();
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [13:0] s, input logic [13:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wait_hold(input logic v, input int lim);
    n = 0;
    while (hold !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      errors++;
      final_report();
    end
  endtask
  // One strobe of sleep request (0), interrupt wake (1) or watchdog timeout (2)
  task pulse(input logic [1:0] sel);
    sleep_req <= (sel == 2'h0);
    irq_wake <= (sel == 2'h1);
    wdt_timeout <= (sel == 2'h2);
    @(posedge clk);
    sleep_req <= 1'b0;
    irq_wake <= 1'b0;
    wdt_timeout <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    rst_n = 1'b0;
    por_req = 1'b0;
    osc_in_pin = 1'b0;
    wdt_timeout = 1'b0;
    irq_wake = 1'b0;
    sleep_req = 1'b0;
    ext_reset_pin_n = 1'b1;
    osc_run = 1'b1;
    repeat (12) @(posedge clk);
    chk({hold, cp, wdt_on, osc_sel}, 14'h0027);
    rst_n <= 1'b1;
    wait_hold(1'b0, 10);
    chk({dec, wdt_on, gated_n}, {8'h5F, 2'b11});
    u_cdw_prog_model.prog(1'b1);
    for (int i = 0; i < 5; i++) begin
      u_cdw_prog_model.wr(`CDW_ADDR_CFG1, rows[i].word);
      repeat (3) @(posedge clk);
      chk(dec, rows[i].exp);
      chk(wdt_on, rows[i].word[2]);
      chk(osc2_io, {rows[i].word[4], rows[i].word[1:0]} == 3'h3);
      chk(gated_n, 1'b1);
      u_cdw_prog_model.rd(`CDW_ADDR_CFG1, d);
      chk(d, rows[i].word);
    end
    u_cdw_prog_model.wr(`CDW_ADDR_CFG2, 14'h0000);
    u_cdw_prog_model.rd(`CDW_ADDR_CFG2, d);
    chk(d, 14'h3FBC);
    u_cdw_prog_model.wr(`CDW_ADDR_CFG2, 14'h3FFF);
    u_cdw_prog_model.wr(`CDW_ADDR_CFG1, 14'h3FAF);
    osc_run = 1'b0;
    u_cdw_prog_model.prog(1'b0);
    wait_hold(1'b0, 10);
    u_cdw_prog_model.wr(`CDW_ADDR_PWRCTL, 14'h0004);
    repeat (3) @(posedge clk);
    chk(bo_act, 1'b1);
    u_cdw_prog_model.rd(`CDW_ADDR_PWRCTL, d);
    chk(d, 14'h0004);
    u_cdw_prog_model.wr(`CDW_ADDR_PWRCTL, 14'h0000);
    repeat (3) @(posedge clk);
    chk(bo_act, 1'b0);
    u_cdw_prog_model.wr(`CDW_ADDR_CFG1, 14'h0000);
    u_cdw_prog_model.rd(`CDW_ADDR_CFG1, d);
    chk(d, 14'h0000);
    chk(dec, 8'h5B);
    u_cdw_prog_model.rd(14'h0100, d);
    chk(d, 14'h0000);
    ext_reset_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({hold, gated_n}, 2'b10);
    ext_reset_pin_n <= 1'b1;
    wait_hold(1'b0, 10);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk);
      seen = seen | hold;
    end
    chk(seen, 1'b1);
    pulse(2'h0);
    chk(sleeping, 1'b1);
    pulse(2'h1);
    chk({sleeping, hold}, 2'b00);
    u_cdw_prog_model.prog(1'b1);
    u_cdw_prog_model.wr(`CDW_ADDR_CFG2, 14'h0000);
    u_cdw_prog_model.wr(`CDW_ADDR_CFG1, 14'h3FE5);
    u_cdw_prog_model.prog(1'b0);
    repeat (40) @(posedge clk);
    chk(hold, 1'b1);
    rises = 0;
    osc_run = 1'b1;
    wait_hold(1'b0, 300);
    chk(rises >= 8, 1'b1);
    chk(bo_act, 1'b1);
    por_req <= 1'b1;
    @(posedge clk);
    por_req <= 1'b0;
    repeat (15) @(posedge clk);
    chk(hold, 1'b1);
    wait_hold(1'b0, 300);
    chk(n > 5, 1'b1);
    pulse(2'h0);
    chk({sleeping, bo_act}, 2'b10);
    u_cdw_prog_model.rd(`CDW_ADDR_STATUS, d);
    chk(d, 14'h0004);
    pulse(2'h2);
    chk(sleeping, 1'b0);
    wait_hold(1'b0, 300);
    final_report();
  end
endmodule
